/* File: core/rmci_pkg.sv */
// Constants shared by the radio module command interpreter
package rmci_pkg;
  localparam int FRAME_LEN = 14;
  localparam logic [3:0] LAST_IDX = 4'hd;
  localparam logic [7:0] SYNC_FIRST = 8'ha5;
  localparam logic [7:0] SYNC_SECOND = 8'h5a;
  localparam logic [7:0] HDR_HOST = 8'hab;
  localparam logic [7:0] HDR_REPLY = 8'h8b;
  // Command origin codes
  localparam logic [7:0] ORG_WRITE_ID_BASE = 8'h18;
  localparam logic [7:0] ORG_QUERY_ID_BASE = 8'h58;
  localparam logic [7:0] ORG_SET_GAIN = 8'h08;
  localparam logic [7:0] ORG_QUERY_GAIN = 8'h48;
  localparam logic [7:0] ORG_RESET = 8'h0a;
  localparam logic [7:0] ORG_QUERY_FIRMWARE_REVISION = 8'h4b;
  // Reply origin codes
  localparam logic [7:0] ORG_OK = 8'h58;
  localparam logic [7:0] ORG_FAIL = 8'h19;
  localparam logic [7:0] ORG_BASE_OUT_OF_SPAN_FAULT = 8'h1a;
  localparam logic [7:0] ORG_ID_BASE_REPORT = 8'h98;
  localparam logic [7:0] ORG_GAIN_LEVEL_REPORT = 8'h88;
  localparam logic [7:0] ORG_FIRMWARE_REVISION_REPORT = 8'h8c;
  localparam logic [7:0] ORG_TX_ID_SPAN_FAULT = 8'h22;
  // Syntax fault field codes
  localparam logic [7:0] SYN_HEADER_SEQUENCE_CODE = 8'h08;
  localparam logic [7:0] SYN_LENGTH = 8'h09;
  localparam logic [7:0] SYN_FRAME_SUM_BYTE = 8'h0a;
  localparam logic [7:0] SYN_ORIGIN_CODE = 8'h0b;
  // Gain level encoding
  localparam logic [7:0] GAIN_LOW = 8'h00;
  localparam logic [7:0] GAIN_HIGH = 8'h01;
  // ID base span and rewrite limit
  localparam logic [8:0] SPAN_TOP_BITS = 9'h1ff;
  localparam int KEPT_BITS = 25;
  localparam logic [3:0] MAX_REWRITES = 4'ha;
  localparam logic [31:0] BASE_RESET = 32'hff800000;
  localparam logic [31:0] UNIQUE_ID_DEFAULT = 32'h00000100;
  localparam logic [31:0] FW_REV_DEFAULT = 32'h01000100;
  localparam logic [31:0] IF_REV_DEFAULT = 32'h01000000;
  // Register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_BASE = 8'h08;
  localparam logic [7:0] REG_INFO = 8'h0c;
  localparam logic [7:0] REG_CTRL = 8'h10;
  // Status bit positions
  localparam int ST_FRAME = 0;
  localparam int ST_SYNTAX = 1;
  localparam int ST_TX_FAULT = 2;
  localparam int ST_REWRITE = 3;
  localparam int ST_RESET = 4;
  localparam int ST_W = 5;
  localparam logic [ST_W-1:0] MASK_RESET = 5'h00;
  localparam logic [0:0] CTRL_RESET = 1'h1;
  // Info field positions
  localparam int INFO_GAIN = 0;
  localparam int INFO_CNT_LO = 8;
  localparam int INFO_SYN_LO = 16;
endpackage : rmci_pkg

/* File: core/rmci_rx_frame.sv */
// Host frame collector with sync, header and sum checks
`timescale 1ns/1ns
`default_nettype none
module rmci_rx_frame
  import rmci_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic [7:0] byte_i,
  input wire logic byte_valid_i,
  output logic busy_o,
  output logic done_o,
  output logic err_o,
  output logic [7:0] err_code_o,
  output logic [7:0] org_o,
  output logic [31:0] pay_o
);
  logic [3:0] idx_r;
  logic [7:0] sum_r;
  logic [3:0] idx_nxt;
  logic [7:0] sum_nxt;
  logic done_nxt;
  logic err_nxt;
  logic [7:0] code_nxt;

  assign busy_o = (idx_r != 4'h0);

  always_comb begin
    idx_nxt = idx_r;
    sum_nxt = sum_r;
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    code_nxt = err_code_o;
    if (byte_valid_i) begin
      idx_nxt = idx_r + 4'h1;
      sum_nxt = sum_r + byte_i;
      case (idx_r)
        4'h0: begin
          // Noise between frames is skipped while hunting for sync
          if (byte_i != SYNC_FIRST) idx_nxt = 4'h0;
        end
        4'h1: begin
          if (byte_i != SYNC_SECOND) begin
            idx_nxt = 4'h0;
            err_nxt = 1'b1;
            code_nxt = SYN_HEADER_SEQUENCE_CODE;
          end
        end
        4'h2: begin
          sum_nxt = byte_i;
          if (byte_i != HDR_HOST) begin
            idx_nxt = 4'h0;
            err_nxt = 1'b1;
            code_nxt = SYN_LENGTH;
          end
        end
        LAST_IDX: begin
          idx_nxt = 4'h0;
          sum_nxt = sum_r;
          if (byte_i != sum_r) begin
            err_nxt = 1'b1;
            code_nxt = SYN_FRAME_SUM_BYTE;
          end else begin
            done_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      idx_r <= 4'h0;
      sum_r <= 8'h00;
      done_o <= 1'b0;
      err_o <= 1'b0;
      err_code_o <= 8'h00;
      org_o <= 8'h00;
      pay_o <= 32'h0;
    end else begin
      idx_r <= idx_nxt;
      sum_r <= sum_nxt;
      done_o <= done_nxt;
      err_o <= err_nxt;
      err_code_o <= code_nxt;
      if (byte_valid_i && idx_r == 4'h3) org_o <= byte_i;
      // Payload bytes past the fourth are never used by a command
      if (byte_valid_i && idx_r >= 4'h4 && idx_r <= 4'h7) pay_o <= {pay_o[23:0], byte_i};
    end
  end
endmodule : rmci_rx_frame
`default_nettype wire

/* File: core/rmci_tx_frame.sv */
// Reply frame serializer with sum generation
`timescale 1ns/1ns
`default_nettype none
module rmci_tx_frame
  import rmci_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] org_i,
  input wire logic [71:0] pay_i,
  output logic busy_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i
);
  logic [3:0] idx_r;
  logic [7:0] org_r;
  logic [71:0] pay_r;
  logic [7:0] sum_r;
  logic [7:0] start_sum;
  logic [7:0] next_byte;
  logic [3:0] next_idx;

  function automatic logic [7:0] frame_sum(input logic [7:0] origin_code, input logic [71:0] pay);
    logic [7:0] s;
    s = HDR_REPLY + origin_code;
    for (int i = 0; i < 9; i++) s = s + pay[i*8 +: 8];
    return s;
  endfunction : frame_sum

  assign start_sum = frame_sum(org_i, pay_i);
  assign busy_o = tx_valid_o;
  assign next_idx = idx_r + 4'h1;
  // Past the sum byte the index runs off the payload; park the data at zero
  assign next_byte = (next_idx > LAST_IDX) ? 8'h00 :
                     (next_idx == 4'h1) ? SYNC_SECOND :
                     (next_idx == 4'h2) ? HDR_REPLY :
                     (next_idx == 4'h3) ? org_r :
                     (next_idx == LAST_IDX) ? sum_r :
                     pay_r[8'(71 - 8 * (32'(next_idx) - 4)) -: 8];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_r <= 4'h0;
      org_r <= 8'h00;
      pay_r <= 72'h0;
      sum_r <= 8'h00;
      tx_data_o <= 8'h00;
      tx_valid_o <= 1'b0;
    end else if (start_i && !tx_valid_o) begin
      idx_r <= 4'h0;
      org_r <= org_i;
      pay_r <= pay_i;
      sum_r <= start_sum;
      tx_data_o <= SYNC_FIRST;
      tx_valid_o <= 1'b1;
    end else if (tx_valid_o && tx_ready_i) begin
      idx_r <= next_idx;
      tx_data_o <= next_byte;
      if (idx_r == LAST_IDX) begin
        tx_valid_o <= 1'b0;
        idx_r <= 4'h0;
      end
    end
  end
endmodule : rmci_tx_frame
`default_nettype wire

/* File: core/rmci_top.sv */
// Radio module command interpreter with Wishbone registers
//
// The Wishbone interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module rmci_top
  import rmci_pkg::*;
#(
  parameter logic [31:0] UNIQUE_ID = UNIQUE_ID_DEFAULT,  // Arbitrary value
  parameter logic [31:0] FW_REV = FW_REV_DEFAULT,        // Arbitrary value
  parameter logic [31:0] IF_REV = IF_REV_DEFAULT         // Arbitrary value
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic [7:0] host_rx_data_i,
  input wire logic host_rx_valid_i,
  output logic host_rx_ready_o,
  output logic [7:0] host_tx_data_o,
  output logic host_tx_valid_o,
  input wire logic host_tx_ready_i,
  input wire logic radio_tx_valid_i,
  input wire logic [31:0] radio_tx_id_i,
  output logic radio_tx_ready_o,
  output logic radio_tx_go_o,
  input wire logic radio_rx_valid_i,
  input wire logic radio_rx_near_i,
  output logic radio_rx_accept_o,
  output logic low_gain_o,
  output logic ctrl_reset_o
);
  // Registers
  logic [31:0] base_r;
  logic [3:0] rewrites_r;
  logic high_gain_r;
  logic [ST_W-1:0] status_r;
  logic [ST_W-1:0] mask_r;
  logic [0:0] ctrl_r;
  logic [7:0] last_syn_r;
  logic rep_pend_r;
  logic [7:0] rep_org_r;
  logic [71:0] rep_pay_r;
  logic soft_rst_r;

  // Frame collector outputs
  logic rx_busy;
  logic rx_done;
  logic rx_err;
  logic [7:0] rx_err_code;
  logic [7:0] rx_org;
  logic [31:0] rx_pay;
  logic rx_byte_take;
  logic tx_busy;
  logic tx_start;

  assign host_rx_ready_o = !rep_pend_r;
  assign rx_byte_take = host_rx_valid_i && host_rx_ready_o;

  rmci_rx_frame u_rx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(soft_rst_r),
    .byte_i(host_rx_data_i),
    .byte_valid_i(rx_byte_take),
    .busy_o(rx_busy),
    .done_o(rx_done),
    .err_o(rx_err),
    .err_code_o(rx_err_code),
    .org_o(rx_org),
    .pay_o(rx_pay)
  );

  assign tx_start = rep_pend_r && !tx_busy;

  rmci_tx_frame u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(tx_start),
    .org_i(rep_org_r),
    .pay_i(rep_pay_r),
    .busy_o(tx_busy),
    .tx_data_o(host_tx_data_o),
    .tx_valid_o(host_tx_valid_o),
    .tx_ready_i(host_tx_ready_i)
  );

  // Command decode
  wire cmd_on = ctrl_r[0];
  wire cmd_valid = rx_done && cmd_on;
  wire syn_valid = rx_err && cmd_on;
  wire is_wr_base = (rx_org == ORG_WRITE_ID_BASE);
  wire is_rd_base = (rx_org == ORG_QUERY_ID_BASE);
  wire is_set_gain = (rx_org == ORG_SET_GAIN);
  wire is_rd_gain = (rx_org == ORG_QUERY_GAIN);
  wire is_reset = (rx_org == ORG_RESET);
  wire is_rd_fw = (rx_org == ORG_QUERY_FIRMWARE_REVISION);
  wire known_org = is_wr_base || is_rd_base || is_set_gain || is_rd_gain || is_reset || is_rd_fw;
  wire limit_hit = (rewrites_r >= MAX_REWRITES);
  wire in_span = (rx_pay[31:23] == SPAN_TOP_BITS);
  wire rewrite_ok = cmd_valid && is_wr_base && !limit_hit && in_span;
  wire gain_low_req = (rx_pay[31:24] == GAIN_LOW);
  wire gain_high_req = (rx_pay[31:24] == GAIN_HIGH);
  wire gain_ok = cmd_valid && is_set_gain && (gain_low_req || gain_high_req);
  wire reset_cmd = cmd_valid && is_reset;
  wire [7:0] gain_byte = high_gain_r ? GAIN_HIGH : GAIN_LOW;

  // Reply selection; lower bytes stay zero where unused
  logic reply_set;
  logic [7:0] reply_org;
  logic [71:0] reply_pay;

  always_comb begin
    reply_set = 1'b0;
    reply_org = ORG_FAIL;
    reply_pay = 72'h0;
    if (syn_valid) begin
      reply_set = 1'b1;
      reply_org = rx_err_code;
    end else if (cmd_valid) begin
      reply_set = !is_reset;
      if (!known_org) begin
        reply_org = SYN_ORIGIN_CODE;
      end else if (is_wr_base) begin
        if (limit_hit) reply_org = ORG_FAIL;
        else if (!in_span) reply_org = ORG_BASE_OUT_OF_SPAN_FAULT;
        else reply_org = ORG_OK;
      end else if (is_rd_base) begin
        reply_org = ORG_ID_BASE_REPORT;
        reply_pay = {base_r, 40'h0};
      end else if (is_set_gain) begin
        // A level code other than low or high cannot be carried out
        reply_org = gain_ok ? ORG_OK : ORG_FAIL;
      end else if (is_rd_gain) begin
        reply_org = ORG_GAIN_LEVEL_REPORT;
        reply_pay = {gain_byte, 64'h0};
      end else if (is_rd_fw) begin
        reply_org = ORG_FIRMWARE_REVISION_REPORT;
        reply_pay = {FW_REV, IF_REV, 8'h00};
      end
    end
  end

  // Outgoing radio telegram ID check; blocked while a host frame is in flight
  // so that a fault reply cannot collide with a command reply
  wire radio_in_range = (radio_tx_id_i == UNIQUE_ID) || (radio_tx_id_i[31:7] == base_r[31:7]);
  assign radio_tx_ready_o = !rep_pend_r && !rx_busy && !rx_done && !rx_err;
  wire radio_take = radio_tx_valid_i && radio_tx_ready_o;
  assign radio_tx_go_o = radio_take && radio_in_range;
  wire radio_fault = radio_take && !radio_in_range;

  // Receive gating by gain level
  assign radio_rx_accept_o = radio_rx_valid_i && (high_gain_r || radio_rx_near_i);
  assign low_gain_o = !high_gain_r;
  assign ctrl_reset_o = soft_rst_r;

  // Wishbone slave
  wire wb_req = wb_cyc_i && wb_stb_i;
  wire wb_wr = wb_req && wb_we_i && wb_ack_o;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wval = wb_dat_i & wmask;
  wire sel_status = (wb_adr_i == REG_STATUS);
  wire sel_mask = (wb_adr_i == REG_MASK);
  wire sel_base = (wb_adr_i == REG_BASE);
  wire sel_info = (wb_adr_i == REG_INFO);
  wire sel_ctrl = (wb_adr_i == REG_CTRL);
  wire [31:0] info_word = {8'h00, last_syn_r, 4'h0, rewrites_r, 7'h00, high_gain_r};
  wire [31:0] rd_word = sel_status ? {27'h0, status_r} :
                        sel_mask ? {27'h0, mask_r} :
                        sel_base ? base_r :
                        sel_info ? info_word :
                        sel_ctrl ? {31'h0, ctrl_r} : 32'h0;

  // Interrupt events; a set in the clearing cycle survives
  wire [ST_W-1:0] st_set = {reset_cmd, rewrite_ok, radio_fault, syn_valid || (cmd_valid && !known_org), cmd_valid};
  wire [ST_W-1:0] st_clr = (wb_wr && sel_status) ? wval[ST_W-1:0] : {ST_W{1'b0}};
  wire [ST_W-1:0] status_nxt = (status_r & ~st_clr) | st_set;

  assign irq_o = |(status_r & mask_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      status_r <= {ST_W{1'b0}};
      mask_r <= MASK_RESET;
      ctrl_r <= CTRL_RESET;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      if (wb_req && !wb_ack_o) wb_dat_o <= rd_word;
      status_r <= status_nxt;
      if (wb_wr && sel_mask) mask_r <= (mask_r & ~wmask[ST_W-1:0]) | wval[ST_W-1:0];
      if (wb_wr && sel_ctrl && wb_sel_i[0]) ctrl_r <= wb_dat_i[0:0];
    end
  end

  // Command state; base and rewrite count stand for nonvolatile storage
  // and so survive the reset command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_r <= BASE_RESET;
      rewrites_r <= 4'h0;
      high_gain_r <= 1'b1;
      last_syn_r <= 8'h00;
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= reset_cmd;
      if (rewrite_ok) begin
        base_r <= {rx_pay[31:32-KEPT_BITS], {(32-KEPT_BITS){1'b0}}};
        rewrites_r <= rewrites_r + 4'h1;
      end
      if (gain_ok) high_gain_r <= gain_high_req;
      if (syn_valid) last_syn_r <= rx_err_code;
      else if (cmd_valid && !known_org) last_syn_r <= SYN_ORIGIN_CODE;
      if (reset_cmd) high_gain_r <= 1'b1;
    end
  end

  // Single reply slot; the host link is stalled while it is full
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rep_pend_r <= 1'b0;
      rep_org_r <= 8'h00;
      rep_pay_r <= 72'h0;
    end else if (reply_set) begin
      rep_pend_r <= 1'b1;
      rep_org_r <= reply_org;
      rep_pay_r <= reply_pay;
    end else if (radio_fault) begin
      rep_pend_r <= 1'b1;
      rep_org_r <= ORG_TX_ID_SPAN_FAULT;
      rep_pay_r <= 72'h0;
    end else if (tx_start) begin
      rep_pend_r <= 1'b0;
    end
  end
endmodule : rmci_top
`default_nettype wire

/* File: sim/rmci_monitor.sv */
// Port checker for the radio module command interpreter
`timescale 1ns/1ns
`default_nettype none
module rmci_monitor
  import rmci_pkg::*;
#(
  parameter logic [31:0] UNIQUE_ID = UNIQUE_ID_DEFAULT
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] host_tx_data_o,
  input wire logic host_tx_valid_o,
  input wire logic host_tx_ready_i,
  input wire logic radio_tx_valid_i,
  input wire logic [31:0] radio_tx_id_i,
  input wire logic radio_tx_ready_o,
  input wire logic radio_tx_go_o,
  input wire logic radio_rx_valid_i,
  input wire logic radio_rx_near_i,
  input wire logic radio_rx_accept_o,
  input wire logic low_gain_o,
  input wire logic ctrl_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] idx_r;
  logic [7:0] sum_r;
  wire take = host_tx_valid_o && host_tx_ready_i;
  // Byte position and running sum; assumes replies start at a frame boundary after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_r <= 4'h0;
      sum_r <= 8'h00;
    end else if (take) begin
      idx_r <= (idx_r == LAST_IDX) ? 4'h0 : idx_r + 4'h1;
      sum_r <= (idx_r < 4'h2) ? 8'h00 : sum_r + host_tx_data_o;
    end
  end
  sync_first_a: assert property (take && idx_r == 4'h0 |-> host_tx_data_o == SYNC_FIRST)
    else $error("reply frame lacks first sync byte");
  reply_header_a: assert property (take && idx_r == 4'h2 |-> host_tx_data_o == HDR_REPLY)
    else $error("reply frame lacks reply header");
  frame_sum_a: assert property (take && idx_r == LAST_IDX |-> host_tx_data_o == sum_r)
    else $error("reply sum byte wrong");
  byte_hold_a: assert property (host_tx_valid_o && !host_tx_ready_i |=> host_tx_valid_o && $stable(host_tx_data_o))
    else $error("reply byte changed before taken");
  go_cause_a: assert property (radio_tx_go_o |-> radio_tx_valid_i && radio_tx_ready_o)
    else $error("radio go without a taken request");
  go_span_a: assert property (radio_tx_go_o |-> radio_tx_id_i == UNIQUE_ID || radio_tx_id_i[31:23] == SPAN_TOP_BITS)
    else $error("radio go for an id out of range");
  near_only_a: assert property (radio_rx_accept_o == (radio_rx_valid_i && (!low_gain_o || radio_rx_near_i)))
    else $error("receive accept ignores gain level");
  reset_pulse_a: assert property (ctrl_reset_o |=> !ctrl_reset_o ##[0:2] !low_gain_o)
    else $error("controller reset pulse or gain restore wrong");
endmodule : rmci_monitor
bind rmci_top rmci_monitor #(.UNIQUE_ID(UNIQUE_ID)) u_rmci_monitor (.clk_i(clk_i), .rst_i(rst_i),
  .host_tx_data_o(host_tx_data_o), .host_tx_valid_o(host_tx_valid_o), .host_tx_ready_i(host_tx_ready_i),
  .radio_tx_valid_i(radio_tx_valid_i), .radio_tx_id_i(radio_tx_id_i), .radio_tx_ready_o(radio_tx_ready_o),
  .radio_tx_go_o(radio_tx_go_o), .radio_rx_valid_i(radio_rx_valid_i), .radio_rx_near_i(radio_rx_near_i),
  .radio_rx_accept_o(radio_rx_accept_o), .low_gain_o(low_gain_o), .ctrl_reset_o(ctrl_reset_o));
`default_nettype wire

/* File: sim/rmci_host.sv */
// Host controller model on the serial command link
`timescale 1ns/1ns
`default_nettype none
module rmci_host
  import rmci_pkg::*;
(
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic rx_ready_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output var logic [7:0] rx_data_o,
  output var logic rx_valid_o,
  output var logic tx_ready_o
);
  logic [7:0] q[$];
  logic [1:0] pace_r;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b1;
    pace_r = 2'h0;
  end
  // Slow mode is ready for reply bytes one cycle in four to stall the serializer
  always @(posedge clk_i) begin
    pace_r <= pace_r + 2'h1;
    tx_ready_o <= !slow_i || pace_r == 2'h0;
    if (tx_valid_i && tx_ready_o) q.push_back(tx_data_i);
  end
  task send(input logic [7:0] s2, input logic [7:0] hdr, input logic [7:0] origin_code, input logic [31:0] pay,
            input logic [7:0] adj);
    logic [7:0] b [14];
    b = '{SYNC_FIRST, s2, hdr, origin_code, pay[31:24], pay[23:16], pay[15:8], pay[7:0], 8'h00, 8'h00, 8'h00, 8'h00,
          8'h00, 8'h00};
    for (int i = 2; i < 13; i++) b[13] = b[13] + b[i];
    b[13] = b[13] + adj;
    @(posedge clk_i);
    for (int i = 0; i < 14; i++) begin
      rx_data_o <= b[i];
      rx_valid_o <= 1'b1;
      @(posedge clk_i);
      while (rx_ready_i !== 1'b1) @(posedge clk_i);
    end
    rx_valid_o <= 1'b0;
    rx_data_o <= ~b[13];
  endtask : send
endmodule : rmci_host
`default_nettype wire

/* File: sim/test_radio_module_cmd_interpreter.sv */
// Self-checking bench for the radio module command interpreter
`timescale 1ns/1ns
`default_nettype none
module test_radio_module_cmd_interpreter
  import rmci_pkg::*;
;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, host_rx_valid_i, host_rx_ready_o, gh, slow;
  logic host_tx_valid_o, host_tx_ready_i, radio_tx_valid_i, radio_tx_ready_o, radio_tx_go_o;
  logic radio_rx_valid_i, radio_rx_near_i, radio_rx_accept_o, low_gain_o, ctrl_reset_o;
  logic [7:0] wb_adr_i, host_rx_data_i, host_tx_data_o, eo;
  logic [7:0] gl [4];
  logic [3:0] wb_sel_i, cnt;
  logic [31:0] wb_dat_i, wb_dat_o, radio_tx_id_i, base_m, v;
  int fails, n_checks, seed, n;
  rmci_top u_rmci_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .host_rx_data_i(host_rx_data_i), .host_rx_valid_i(host_rx_valid_i),
    .host_rx_ready_o(host_rx_ready_o), .host_tx_data_o(host_tx_data_o), .host_tx_valid_o(host_tx_valid_o),
    .host_tx_ready_i(host_tx_ready_i), .radio_tx_valid_i(radio_tx_valid_i), .radio_tx_id_i(radio_tx_id_i),
    .radio_tx_ready_o(radio_tx_ready_o), .radio_tx_go_o(radio_tx_go_o), .radio_rx_valid_i(radio_rx_valid_i),
    .radio_rx_near_i(radio_rx_near_i), .radio_rx_accept_o(radio_rx_accept_o), .low_gain_o(low_gain_o),
    .ctrl_reset_o(ctrl_reset_o));
  rmci_host u_rmci_host (.clk_i(clk_i), .slow_i(slow), .rx_ready_i(host_rx_ready_o), .tx_data_i(host_tx_data_o),
    .tx_valid_i(host_tx_valid_o), .rx_data_o(host_rx_data_i), .rx_valid_o(host_rx_valid_i),
    .tx_ready_o(host_tx_ready_i));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && k < 50) begin
      @(posedge clk_i);
      k++;
    end
    if (!we || k >= 50) chk(k < 50 ? wb_dat_o : 32'hx, exp);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task reply(input logic [7:0] origin_code, input logic [31:0] a, input logic [31:0] b);
    logic [7:0] e [14];
    int k;
    k = 0;
    while (u_rmci_host.q.size() < 14 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    e = '{SYNC_FIRST, SYNC_SECOND, HDR_REPLY, origin_code, a[31:24], a[23:16], a[15:8], a[7:0], b[31:24], b[23:16],
          b[15:8], b[7:0], 8'h00, 8'h00};
    for (int i = 2; i < 13; i++) e[13] = e[13] + e[i];
    for (int i = 0; i < 14; i++) chk(u_rmci_host.q.size() > 0 ? u_rmci_host.q.pop_front() : 8'hxx, e[i]);
  endtask : reply
  task cmd(input logic [7:0] origin_code, input logic [31:0] pay);
    u_rmci_host.send(SYNC_SECOND, HDR_HOST, origin_code, pay, 8'h00);
  endtask : cmd
  task gain(input logic [7:0] g);
    cmd(ORG_SET_GAIN, {g, 24'h0});
    if (g > GAIN_HIGH) reply(ORG_FAIL, 0, 0);
    else reply(ORG_OK, 0, 0);
    if (g <= GAIN_HIGH) gh = g[0];
    chk(low_gain_o, !gh);
    cmd(ORG_QUERY_GAIN, 0);
    reply(ORG_GAIN_LEVEL_REPORT, {7'h0, gh, 24'h0}, 0);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      chk(radio_rx_accept_o, radio_rx_valid_i && (gh || radio_rx_near_i));
      v = $random(seed);
      radio_rx_valid_i <= v[0];
      radio_rx_near_i <= v[1];
    end
  endtask : gain
  task rtx(input logic [31:0] id, input logic ok);
    n = 0;
    @(posedge clk_i);
    radio_tx_valid_i <= 1'b1;
    radio_tx_id_i <= id;
    @(posedge clk_i);
    while (radio_tx_ready_o !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk(radio_tx_go_o, ok);
    radio_tx_valid_i <= 1'b0;
    radio_tx_id_i <= ~id;
    if (!ok) reply(ORG_TX_ID_SPAN_FAULT, 0, 0);
  endtask : rtx
  initial begin
    repeat (40000) @(posedge clk_i);
    fails++;
    conclude();
  end
  initial begin
    seed = 346;
    fails = 0;
    n_checks = 0;
    cnt = 4'h0;
    gh = 1'b1;
    slow = 1'b0;
    base_m = BASE_RESET;
    gl = '{GAIN_LOW, 8'h02, GAIN_HIGH, GAIN_LOW};
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {radio_tx_valid_i, radio_tx_id_i, radio_rx_valid_i, radio_rx_near_i} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, REG_INFO, 0, 32'h1);
    bus(0, REG_CTRL, 0, 32'h1);
    bus(0, 8'h20, 0, 32'h0);
    bus(1, REG_BASE, 32'h0, 0);
    bus(0, REG_BASE, 0, BASE_RESET);
    bus(1, REG_MASK, 32'h1f, 0);
    cmd(ORG_QUERY_FIRMWARE_REVISION, 0);
    reply(ORG_FIRMWARE_REVISION_REPORT, FW_REV_DEFAULT, IF_REV_DEFAULT);
    for (int i = 0; i < 4; i++) gain(gl[i]);
    bus(1, REG_STATUS, 32'h1f, 0);
    // Field codes run 08..0b in the order sync, header, sum, origin
    for (int k = 0; k < 4; k++) begin
      u_rmci_host.send(k == 0 ? 8'h5b : SYNC_SECOND, k == 1 ? 8'hac : HDR_HOST, k == 3 ? 8'h77 : ORG_QUERY_GAIN, 0,
                       k == 2 ? 8'h01 : 8'h00);
      eo = SYN_HEADER_SEQUENCE_CODE + 8'(k);
      reply(eo, 0, 0);
      bus(0, REG_INFO, 0, {8'h00, eo, 4'h0, cnt, 7'h00, gh});
    end
    // The unknown-origin frame has a good sum, so it also counts as a frame
    bus(0, REG_STATUS, 0, 32'h3);
    chk(irq_o, 1'b1);
    bus(1, REG_MASK, 32'h1c, 0);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
    bus(1, REG_MASK, 32'h1f, 0);
    bus(1, REG_STATUS, 32'h3, 0);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
    slow <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      v[31:23] = (i % 4 == 3) ? {1'b0, v[30:23]} : SPAN_TOP_BITS;
      if (i == 0) v = 32'hff80007f;
      cmd(ORG_WRITE_ID_BASE, v);
      if (cnt >= MAX_REWRITES) eo = ORG_FAIL;
      else if (v[31:23] != SPAN_TOP_BITS) eo = ORG_BASE_OUT_OF_SPAN_FAULT;
      else begin
        eo = ORG_OK;
        base_m = {v[31:7], 7'h00};
        cnt = cnt + 4'h1;
      end
      reply(eo, 0, 0);
    end
    slow <= 1'b0;
    cmd(ORG_QUERY_ID_BASE, 0);
    reply(ORG_ID_BASE_REPORT, base_m, 0);
    bus(0, REG_BASE, 0, base_m);
    bus(0, REG_INFO, 0, {8'h00, SYN_ORIGIN_CODE, 4'h0, cnt, 7'h00, gh});
    rtx(UNIQUE_ID_DEFAULT, 1'b1);
    rtx(base_m | 32'h55, 1'b1);
    rtx(base_m ^ 32'h80, 1'b0);
    rtx(32'h12345678, 1'b0);
    cmd(ORG_RESET, 0);
    n = 0;
    while (ctrl_reset_o !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk(ctrl_reset_o, 1'b1);
    repeat (30) @(posedge clk_i);
    gh = 1'b1;
    chk(low_gain_o, 1'b0);
    chk(u_rmci_host.q.size(), 0);
    bus(0, REG_BASE, 0, base_m);
    // Disabled interpreter must stay silent
    bus(1, REG_CTRL, 32'h0, 0);
    cmd(ORG_QUERY_GAIN, 0);
    repeat (60) @(posedge clk_i);
    chk(u_rmci_host.q.size(), 0);
    bus(1, REG_CTRL, 32'h1, 0);
    cmd(ORG_QUERY_GAIN, 0);
    reply(ORG_GAIN_LEVEL_REPORT, {7'h0, gh, 24'h0}, 0);
    conclude();
  end
endmodule : test_radio_module_cmd_interpreter
`default_nettype wire
